// ---- trig_status.sv ----
// Trigger input/output engine with mode report and status registers
// Contract
// - Input trigger enable, readable, off at reset
// - Selectable input edge, falling after reset
// - Input event count readable without change
// - Clear request zeroes input count
// - Output trigger enable, readable, off at reset
// - Output pulse polarity selectable, falling default
// - Output pulse count readable without change
// - Clear request zeroes output count
// - Pulse width in microseconds, default 25
// - Per channel fire at max or min
// - Report operating mode code zero to eight
// - Questionable events clear when read
// - Questionable condition readable as live state
// - Questionable enable mask, one enables bit
// - Operation events latched and readable
// - Operation condition readable as live state
// - Operation enable mask, one enables bit
`timescale 1ns/1ps
`include "trig_status_params.svh"

module trig_status
  import trig_status_pkg::*;
#(
  parameter int NCH   = 4,
  parameter int CNT_W = 32
) (
  input  wire logic           clk_sys,      // System clock, 25 MHz
  input  wire logic           rst_n,        // Async reset, active low
  input  wire logic           ce,           // Clock enable, freezes state when low
  input  wire logic           trig_in_pin,  // External trigger input pin
  input  wire logic [NCH-1:0] wave_max,     // Per-channel waveform maximum pulse
  input  wire logic [NCH-1:0] wave_min,     // Per-channel waveform minimum pulse
  input  wire logic [3:0]     mode_code,    // Current operating mode
  input  wire logic [15:0]    ques_cond,    // Live questionable conditions
  input  wire logic [15:0]    oper_cond,    // Live operation conditions
  input  wire logic           cmd_valid,    // Command strobe
  input  wire cmd_type        cmd,          // Decoded command
  output logic                resp_valid,   // Response strobe
  output resp_type            resp,         // Response data
  output logic                trig_out_pin, // Trigger output pin
  output logic                ques_summary, // Enabled questionable events pending
  output logic                oper_summary  // Enabled operation events pending
);

  localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;
  localparam logic [4:0] CYC_UNIT = 5'(`CYC_PER_UNIT);

  function automatic logic hit(input logic v, input logic w, input logic [4:0] s, input logic [4:0] code);
    hit = v & w & (s == code);
  endfunction

  function automatic logic rd(input logic v, input logic w, input logic [4:0] s, input logic [4:0] code);
    rd = v & ~w & (s == code);
  endfunction

  logic             tin_en;
  logic             tin_type;
  logic [CNT_W-1:0] tin_count;
  logic             tout_en;
  logic             tout_type;
  logic [CNT_W-1:0] tout_count;
  logic [15:0]      tout_width;
  logic [1:0]       chan_pos [NCH];
  logic             pulse_on;
  logic [15:0]      us_left;
  logic [4:0]       sub_cnt;
  logic [15:0]      ques_event;
  logic [15:0]      ques_enable;
  logic [15:0]      ques_prev;
  logic [15:0]      oper_event;
  logic [15:0]      oper_enable;
  logic [15:0]      oper_prev;

  logic in_rise;
  logic in_fall;

  pin_sync #(
    .IDLE (1'b0)
  ) u_in_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .pin     (trig_in_pin),
    .level   (),
    .rise    (in_rise),
    .fall    (in_fall)
  );

  wire we = cmd_valid & ce;

  wire w_tin_state  = hit(we, cmd.write, cmd.sel, `SEL_TIN_STATE);
  wire w_tin_type   = hit(we, cmd.write, cmd.sel, `SEL_TIN_TYPE);
  wire tin_clear    = we & (cmd.sel == `SEL_TIN_CLEAR);
  wire w_tout_state = hit(we, cmd.write, cmd.sel, `SEL_TOUT_STATE);
  wire w_tout_type  = hit(we, cmd.write, cmd.sel, `SEL_TOUT_TYPE);
  wire tout_clear   = we & (cmd.sel == `SEL_TOUT_CLEAR);
  wire w_tout_width = hit(we, cmd.write, cmd.sel, `SEL_TOUT_WIDTH);
  wire w_tout_chan  = hit(we, cmd.write, cmd.sel, `SEL_TOUT_CHAN);
  wire w_ques_en    = hit(we, cmd.write, cmd.sel, `SEL_QUES_ENABLE);
  wire w_oper_en    = hit(we, cmd.write, cmd.sel, `SEL_OPER_ENABLE);
  wire r_ques_event = rd(we, cmd.write, cmd.sel, `SEL_QUES_EVENT);
  wire r_oper_event = rd(we, cmd.write, cmd.sel, `SEL_OPER_EVENT);

  // Qualified input edge, only while enabled
  wire in_edge = tin_en & ((tin_type == `EDGE_RISE) ? in_rise : in_fall);

  // Channel fire events; zero and min behave alike
  logic [NCH-1:0] ch_fire;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      assign ch_fire[g] = (chan_pos[g] == `POS_MAX) ? wave_max[g] : wave_min[g];
    end
  endgenerate

  // A zero width emits nothing; events during a pulse are absorbed, not queued
  wire fire = ce & tout_en & ~pulse_on & (|ch_fire) & (tout_width != 16'h0000);
  wire unit_done = (sub_cnt == CYC_UNIT - 5'h01);
  wire pulse_end = pulse_on & unit_done & (us_left == 16'h0001);

  wire [15:0] ques_rise = ques_cond & ~ques_prev & ques_enable;
  wire [15:0] oper_rise = oper_cond & ~oper_prev & oper_enable;

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tin_en      <= `RST_TIN_EN;
      tin_type    <= `RST_TIN_TYPE;
      tout_en     <= `RST_TOUT_EN;
      tout_type   <= `RST_TOUT_TYPE;
      tout_width  <= `RST_TOUT_WIDTH;
      ques_enable <= `RST_ENABLE;
      oper_enable <= `RST_ENABLE;
    end else begin
      if (w_tin_state)  tin_en      <= cmd.wdata[0];
      if (w_tin_type)   tin_type    <= cmd.wdata[0];
      if (w_tout_state) tout_en     <= cmd.wdata[0];
      if (w_tout_type)  tout_type   <= cmd.wdata[0];
      if (w_tout_width) tout_width  <= cmd.wdata[15:0];
      if (w_ques_en)    ques_enable <= cmd.wdata[15:0];
      if (w_oper_en)    oper_enable <= cmd.wdata[15:0];
    end
  end

  generate
    for (g = 0; g < NCH; g++) begin : g_pos
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          chan_pos[g] <= `POS_ZERO;
        end else if (w_tout_chan && cmd.chan == 4'(g)) begin
          chan_pos[g] <= cmd.wdata[1:0];
        end
      end
    end
  endgenerate

  // Counters; an event in the clear cycle survives as a count of one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tin_count  <= '0;
      tout_count <= '0;
    end else if (ce) begin
      if (tin_clear)
        tin_count <= CNT_W'(in_edge);
      else if (in_edge)
        tin_count <= tin_count + 1'b1;
      if (tout_clear)
        tout_count <= CNT_W'(fire);
      else if (fire)
        tout_count <= tout_count + 1'b1;
    end
  end

  // Pulse timer: microseconds counted down in whole units of clk cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_on <= 1'b0;
      us_left  <= 16'h0000;
      sub_cnt  <= 5'h00;
    end else if (ce) begin
      if (fire) begin
        pulse_on <= 1'b1;
        us_left  <= tout_width;
        sub_cnt  <= 5'h00;
      end else if (pulse_on) begin
        sub_cnt <= unit_done ? 5'h00 : sub_cnt + 5'h01;
        if (unit_done)
          us_left <= us_left - 16'h0001;
        if (pulse_end)
          pulse_on <= 1'b0;
      end
    end
  end

  // Output pin registered; idle level is the inverse of the pulse level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      trig_out_pin <= 1'b1;
    else if (ce)
      trig_out_pin <= ((fire | (pulse_on & ~pulse_end)) ^ (tout_type == `EDGE_RISE)) ? 1'b0 : 1'b1;
  end

  // Event registers; a new event wins over the read-clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ques_event <= 16'h0000;
      oper_event <= 16'h0000;
      ques_prev  <= 16'h0000;
      oper_prev  <= 16'h0000;
    end else if (ce) begin
      ques_prev  <= ques_cond;
      oper_prev  <= oper_cond;
      ques_event <= (r_ques_event ? 16'h0000 : ques_event) | ques_rise;
      oper_event <= (r_oper_event ? 16'h0000 : oper_event) | oper_rise;
    end
  end

  assign ques_summary = |(ques_event & ques_enable);
  assign oper_summary = |(oper_event & oper_enable);

  // Read mux
  logic [31:0] rdata;
  logic        rerr;
  always_comb begin
    rdata = 32'h0000_0000;
    rerr  = 1'b0;
    unique case (cmd.sel)
      `SEL_TIN_STATE:   rdata = {31'h0, tin_en};
      `SEL_TIN_TYPE:    rdata = {31'h0, tin_type};
      `SEL_TIN_COUNT:   rdata = 32'(tin_count);
      `SEL_TIN_CLEAR:   rdata = 32'h0000_0000;
      `SEL_TOUT_STATE:  rdata = {31'h0, tout_en};
      `SEL_TOUT_TYPE:   rdata = {31'h0, tout_type};
      `SEL_TOUT_COUNT:  rdata = 32'(tout_count);
      `SEL_TOUT_CLEAR:  rdata = 32'h0000_0000;
      `SEL_TOUT_WIDTH:  rdata = {16'h0, tout_width};
      `SEL_TOUT_CHAN:   rdata = {30'h0, chan_pos[cmd.chan[CH_W-1:0]]};
      `SEL_MODE:        rdata = {28'h0, mode_code};
      `SEL_QUES_EVENT:  rdata = {16'h0, ques_event};
      `SEL_QUES_COND:   rdata = {16'h0, ques_cond};
      `SEL_QUES_ENABLE: rdata = {16'h0, ques_enable};
      `SEL_OPER_EVENT:  rdata = {16'h0, oper_event};
      `SEL_OPER_COND:   rdata = {16'h0, oper_cond};
      `SEL_OPER_ENABLE: rdata = {16'h0, oper_enable};
      default:          rerr  = 1'b1;
    endcase
    if (cmd.chan >= 4'(NCH) && cmd.sel == `SEL_TOUT_CHAN)
      rerr = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end else if (ce) begin
      resp_valid <= cmd_valid;
      if (cmd_valid) begin
        resp.err  <= rerr;
        resp.data <= (cmd.write | rerr) ? 32'h0000_0000 : rdata;
      end
    end
  end

  // Checker helpers: cycles spent in the current pulse and the width it started with
  logic [20:0] pulse_age;
  logic [15:0] pulse_len;
  wire  [20:0] pulse_last = 21'(pulse_len) * 21'(`CYC_PER_UNIT) - 21'h000001;

  // Counted apart from the timer so a broken sub-count cannot hide its own error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_age <= 21'h000000;
      pulse_len <= 16'h0000;
    end else if (ce) begin
      if (fire) begin
        pulse_age <= 21'h000000;
        pulse_len <= tout_width;
      end else if (pulse_on) begin
        pulse_age <= pulse_age + 21'h000001;
      end
    end
  end

  tin_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !tin_clear && !in_edge |=> tin_count == $past(tin_count))
    else $error("input count changed without an edge");

  tin_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tin_clear && !in_edge |=> tin_count == '0)
    else $error("input count not cleared");

  tin_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !tin_en && !tin_clear |=> $stable(tin_count))
    else $error("input counted while disabled");

  tout_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fire && !tout_clear |=> tout_count == $past(tout_count) + 1'b1)
    else $error("output count missed a pulse");

  tout_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tout_clear && !fire |=> tout_count == '0)
    else $error("output count not cleared");

  tout_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !fire && !pulse_on && $stable(tout_type) |=> trig_out_pin == ($past(tout_type) != `EDGE_RISE))
    else $error("trigger output not at idle level");

  tout_active_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fire |=> trig_out_pin == ($past(tout_type) == `EDGE_RISE))
    else $error("trigger pulse not at active level");

  pulse_unit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && pulse_on && pulse_age == pulse_last |-> pulse_end)
    else $error("pulse has wrong length");

  pulse_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && pulse_on && pulse_age < pulse_last |-> !pulse_end)
    else $error("pulse ended early");

  pulse_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !pulse_on && tout_width == 16'h0000 |=> !pulse_on)
    else $error("zero width started a pulse");

  ques_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r_ques_event && ques_rise == 16'h0000 |=> ques_event == 16'h0000)
    else $error("questionable events not cleared by read");

  oper_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r_oper_event && oper_rise == 16'h0000 |=> oper_event == 16'h0000)
    else $error("operation events not cleared by read");

  ques_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    w_ques_en |=> ques_enable == $past(cmd.wdata[15:0]))
    else $error("questionable enable not written");

  oper_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    w_oper_en |=> oper_enable == $past(cmd.wdata[15:0]))
    else $error("operation enable not written");

  mode_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    we && !cmd.write && cmd.sel == `SEL_MODE |=> resp_valid && resp.data == {28'h0, $past(mode_code)})
    else $error("mode code not returned");

endmodule

// ---- trig_status_params.svh ----
// Constants for the trigger input/output and status register block
`ifndef TRIG_STATUS_PARAMS_SVH
`define TRIG_STATUS_PARAMS_SVH

// Command selector codes
`define SEL_TIN_STATE   5'h00
`define SEL_TIN_TYPE    5'h01
`define SEL_TIN_COUNT   5'h02
`define SEL_TIN_CLEAR   5'h03
`define SEL_TOUT_STATE  5'h04
`define SEL_TOUT_TYPE   5'h05
`define SEL_TOUT_COUNT  5'h06
`define SEL_TOUT_CLEAR  5'h07
`define SEL_TOUT_WIDTH  5'h08
`define SEL_TOUT_CHAN   5'h09
`define SEL_MODE        5'h0A
`define SEL_QUES_EVENT  5'h0B
`define SEL_QUES_COND   5'h0C
`define SEL_QUES_ENABLE 5'h0D
`define SEL_OPER_EVENT  5'h0E
`define SEL_OPER_COND   5'h0F
`define SEL_OPER_ENABLE 5'h10

// Edge and polarity field encoding
`define EDGE_FALL       1'h0
`define EDGE_RISE       1'h1

// Output position encoding per channel
`define POS_ZERO        2'h0
`define POS_MAX         2'h1
`define POS_MIN         2'h2

// Reset values
`define RST_TIN_EN      1'h0
`define RST_TIN_TYPE    1'h0
`define RST_TOUT_EN     1'h0
`define RST_TOUT_TYPE   1'h0
`define RST_TOUT_WIDTH  16'h0019
`define RST_ENABLE      16'h0000

// Timing
`define CLK_PERIOD_NS   40
`define WIDTH_UNIT_NS   1000
`define CYC_PER_UNIT    ((`WIDTH_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- trig_status_pkg.sv ----
// Types shared by the trigger and status block
`include "trig_status_params.svh"

package trig_status_pkg;

  typedef enum logic [4:0] {
    sel_tin_state   = `SEL_TIN_STATE,
    sel_tin_type    = `SEL_TIN_TYPE,
    sel_tin_count   = `SEL_TIN_COUNT,
    sel_tin_clear   = `SEL_TIN_CLEAR,
    sel_tout_state  = `SEL_TOUT_STATE,
    sel_tout_type   = `SEL_TOUT_TYPE,
    sel_tout_count  = `SEL_TOUT_COUNT,
    sel_tout_clear  = `SEL_TOUT_CLEAR,
    sel_tout_width  = `SEL_TOUT_WIDTH,
    sel_tout_chan   = `SEL_TOUT_CHAN,
    sel_mode        = `SEL_MODE,
    sel_ques_event  = `SEL_QUES_EVENT,
    sel_ques_cond   = `SEL_QUES_COND,
    sel_ques_enable = `SEL_QUES_ENABLE,
    sel_oper_event  = `SEL_OPER_EVENT,
    sel_oper_cond   = `SEL_OPER_COND,
    sel_oper_enable = `SEL_OPER_ENABLE
  } cmd_sel_type;

  typedef enum logic [3:0] {
    mode_discrete   = 4'h0,
    mode_triangle   = 4'h1,
    mode_rayleigh   = 4'h2,
    mode_trig_in    = 4'h3,
    mode_tornado    = 4'h4,
    mode_emulation  = 4'h5,
    mode_modulation = 4'h6,
    mode_manual     = 4'h7,
    mode_setup      = 4'h8
  } mode_type;

  typedef struct packed {
    logic        write;
    logic [4:0]  sel;
    logic [3:0]  chan;
    logic [31:0] wdata;
  } cmd_type;

  typedef struct packed {
    logic        err;
    logic [31:0] data;
  } resp_type;

endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps

module pin_sync #(
  parameter logic IDLE = 1'b0
) (
  input  wire logic clk_sys,   // System clock
  input  wire logic rst_n,     // Async reset, active low
  input  wire logic ce,        // Clock enable
  input  wire logic pin,       // Asynchronous pin
  output logic      level,     // Filtered level
  output logic      rise,      // One-cycle rising pulse
  output logic      fall       // One-cycle falling pulse
);

  logic s1;
  logic s2;
  logic s3;
  logic level_d;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1      <= IDLE;
      s2      <= IDLE;
      s3      <= IDLE;
      level   <= IDLE;
      level_d <= IDLE;
    end else if (ce) begin
      s1      <= pin;
      s2      <= s1;
      s3      <= s2;
      level_d <= level;
      // A change counts only once two later stages agree
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

  assign rise = ce & level & ~level_d;
  assign fall = ce & ~level & level_d;

endmodule

// ---- host_model.sv ----
// Remote host model that issues one register command at a time
`timescale 1ns/1ps

module host_model
  import trig_status_pkg::*;
(
  input  wire logic     clk_sys,    // System clock
  output logic          cmd_valid,  // Command strobe
  output cmd_type       cmd,        // Command word
  input  wire logic     resp_valid, // Response strobe
  input  wire resp_type resp        // Response word
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // Word is inverted once released so a design that samples it late sees garbage, not the old command
  task automatic xfer(input logic wr, input logic [4:0] sel, input logic [3:0] ch, input logic [31:0] wd,
                      output resp_type r, output logic got);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd       = {wr, sel, ch, wd};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd       = ~cmd;
    got       = resp_valid;
    r         = resp;
  endtask
endmodule

// ---- trig_status_tb.sv ----
// Self-checking bench for the trigger and status block
`timescale 1ns/1ps

module trig_status_tb
  import trig_status_pkg::*;
;
  logic       clk_sys;
  logic       rst_n;
  logic       ce;
  logic       trig_in_pin;
  logic [3:0] wave_max;
  logic [3:0] wave_min;
  logic [3:0] mode_code;
  logic [15:0] ques_cond;
  logic [15:0] oper_cond;
  logic       cmd_valid;
  cmd_type    cmd;
  logic       resp_valid;
  resp_type   resp;
  logic       trig_out_pin;
  logic       ques_summary;
  logic       oper_summary;
  int         error_cnt;
  int         n_checks;

  trig_status #(.NCH(4), .CNT_W(32)) i_trig_status (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .trig_in_pin(trig_in_pin), .wave_max(wave_max),
    .wave_min(wave_min), .mode_code(mode_code), .ques_cond(ques_cond), .oper_cond(oper_cond),
    .cmd_valid(cmd_valid), .cmd(cmd), .resp_valid(resp_valid), .resp(resp), .trig_out_pin(trig_out_pin),
    .ques_summary(ques_summary), .oper_summary(oper_summary)
  );

  host_model i_host_model (
    .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd), .resp_valid(resp_valid), .resp(resp)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Every command must be answered on the following edge
  task automatic xfer(input logic wr, input logic [4:0] sel, input logic [3:0] ch, input logic [31:0] wd,
                      output resp_type r);
    logic got;
    i_host_model.xfer(wr, sel, ch, wd, r, got);
    check({31'h0, got}, 32'h1);
  endtask

  task automatic wr(input logic [4:0] sel, input logic [31:0] wd);
    resp_type r;
    xfer(1'b1, sel, 4'h0, wd, r);
  endtask

  task automatic rd_chk(input logic [4:0] sel, input logic [31:0] exp);
    resp_type r;
    xfer(1'b0, sel, 4'h0, 32'h0, r);
    check(r.data, exp);
  endtask

  task automatic t_reset_values();
    resp_type r;
    check({31'h0, trig_out_pin}, 32'h1);
    rd_chk(sel_tin_state, 32'h0);
    rd_chk(sel_tin_type, 32'h0);
    rd_chk(sel_tout_state, 32'h0);
    rd_chk(sel_tout_type, 32'h0);
    rd_chk(sel_tout_width, 32'h19);
    rd_chk(sel_ques_enable, 32'h0);
    rd_chk(sel_oper_enable, 32'h0);
    xfer(1'b0, 5'h11, 4'h0, 32'h0, r);
    check({31'h0, r.err}, 32'h1);
    wr(sel_tout_width, 32'hFFFF);
    rd_chk(sel_tout_width, 32'hFFFF);
  endtask

  // Pin held long enough for the synchroniser and filter to settle each way
  task automatic toggle_in();
    repeat (2) begin
      @(negedge clk_sys);
      trig_in_pin = ~trig_in_pin;
      repeat (8) @(negedge clk_sys);
    end
  endtask

  task automatic t_trig_in();
    toggle_in();
    rd_chk(sel_tin_count, 32'h0);
    wr(sel_tin_state, 32'h1);
    rd_chk(sel_tin_state, 32'h1);
    toggle_in();
    rd_chk(sel_tin_count, 32'h1);
    wr(sel_tin_type, 32'h1);
    rd_chk(sel_tin_type, 32'h1);
    toggle_in();
    rd_chk(sel_tin_count, 32'h2);
    rd_chk(sel_tin_count, 32'h2);
    wr(sel_tin_clear, 32'h0);
    rd_chk(sel_tin_count, 32'h0);
    // Edges while the clock enable is low must leave no trace
    ce = 1'b0;
    toggle_in();
    ce = 1'b1;
    rd_chk(sel_tin_count, 32'h0);
  endtask

  task automatic fire(input logic use_max, input int ch, input logic act, input int exp);
    int n;
    n = 0;
    @(negedge clk_sys);
    if (use_max) begin
      wave_max[ch] = 1'b1;
    end else begin
      wave_min[ch] = 1'b1;
    end
    @(negedge clk_sys);
    wave_max = '0;
    wave_min = '0;
    repeat (40) begin
      if (trig_out_pin === act) n++;
      @(negedge clk_sys);
    end
    check(n, exp);
    check({31'h0, trig_out_pin}, {31'h0, ~act});
  endtask

  task automatic t_trig_out();
    resp_type r;
    wr(sel_tout_state, 32'h1);
    rd_chk(sel_tout_state, 32'h1);
    wr(sel_tout_width, 32'h1);
    xfer(1'b1, sel_tout_chan, 4'h0, 32'h1, r);
    xfer(1'b0, sel_tout_chan, 4'h0, 32'h0, r);
    check(r.data, 32'h1);
    fire(1'b0, 0, 1'b0, 0);
    fire(1'b1, 0, 1'b0, 25);
    rd_chk(sel_tout_count, 32'h1);
    rd_chk(sel_tout_count, 32'h1);
    wr(sel_tout_type, 32'h1);
    @(negedge clk_sys);
    check({31'h0, trig_out_pin}, 32'h0);
    fire(1'b0, 1, 1'b1, 25);
    fire(1'b1, 1, 1'b1, 0);
    xfer(1'b1, sel_tout_chan, 4'h2, 32'h2, r);
    fire(1'b0, 2, 1'b1, 25);
    rd_chk(sel_tout_count, 32'h3);
    wr(sel_tout_clear, 32'h0);
    rd_chk(sel_tout_count, 32'h0);
    xfer(1'b0, sel_tout_chan, 4'h4, 32'h0, r);
    check({31'h0, r.err}, 32'h1);
    check(r.data, 32'h0);
    xfer(1'b1, sel_tout_chan, 4'h4, 32'h0, r);
    check({31'h0, r.err}, 32'h1);
    xfer(1'b0, sel_tout_chan, 4'h0, 32'h0, r);
    check(r.data, 32'h1);
    xfer(1'b1, sel_tout_chan, 4'h3, 32'h3, r);
    fire(1'b0, 3, 1'b1, 25);
    rd_chk(sel_tout_count, 32'h1);
    wr(sel_tout_width, 32'h0);
    fire(1'b0, 3, 1'b1, 0);
    rd_chk(sel_tout_count, 32'h1);
  endtask

  task automatic t_mode();
    for (int i = 0; i <= 8; i++) begin
      @(negedge clk_sys);
      mode_code = i[3:0];
      rd_chk(sel_mode, i);
    end
  endtask

  task automatic t_status(input logic oper, input logic [4:0] ev, input logic [4:0] cnd, input logic [4:0] en,
                          input logic [15:0] mask, input logic [15:0] raise, input logic [15:0] exp);
    wr(en, {16'h0, mask});
    rd_chk(en, {16'h0, mask});
    @(negedge clk_sys);
    if (oper) begin
      oper_cond = raise;
    end else begin
      ques_cond = raise;
    end
    repeat (3) @(negedge clk_sys);
    check({31'h0, oper ? oper_summary : ques_summary}, 32'h1);
    rd_chk(ev, {16'h0, exp});
    rd_chk(ev, 32'h0);
    rd_chk(cnd, {16'h0, raise});
    check({31'h0, oper ? oper_summary : ques_summary}, 32'h0);
  endtask

  initial begin
    error_cnt   = 0;
    n_checks    = 0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    trig_in_pin = 1'b0;
    wave_max    = '0;
    wave_min    = '0;
    mode_code   = 4'h0;
    ques_cond   = 16'h0000;
    oper_cond   = 16'h0000;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset_values();
    t_trig_in();
    t_trig_out();
    t_mode();
    t_status(1'b0, sel_ques_event, sel_ques_cond, sel_ques_enable, 16'h0005, 16'h0003, 16'h0001);
    t_status(1'b1, sel_oper_event, sel_oper_cond, sel_oper_enable, 16'h8000, 16'h8001, 16'h8000);
    give_verdict();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    #(100000 * 40);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule
